//--- inc/ioxp_pkg.sv
// constants, types and reset state of the i2c expander register access block
package ioxp_pkg;
    localparam logic [4:0] OWN_ADDR_HI = 5'h1c;
    localparam logic [1:0] REG_INPUT = 2'h0;
    localparam logic [1:0] REG_OUTPUT = 2'h1;
    localparam logic [1:0] REG_POLARITY = 2'h2;
    localparam logic [1:0] REG_CONFIG = 2'h3;
    localparam logic [7:0] OUT_RST = 8'hff;
    localparam logic [7:0] POL_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'hff;
    localparam logic [1:0] PTR_RST = 2'h0;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;

    typedef enum logic [4:0] {
        IOXP_IDLE = 5'h01,
        IOXP_RX = 5'h02,
        IOXP_RACK = 5'h04,
        IOXP_TX = 5'h08,
        IOXP_TACK = 5'h10
    } ioxp_state_t;

    typedef enum logic [2:0] {
        IOXP_K_ADDR = 3'h1,
        IOXP_K_CMD = 3'h2,
        IOXP_K_DATA = 3'h4
    } ioxp_kind_t;

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_s3;
        logic sda_s1;
        logic sda_s2;
        logic sda_s3;
        logic [7:0] pin_s1;
        logic [7:0] pin_s2;
        logic [1:0] adr_s1;
        logic [1:0] adr_s2;
        ioxp_state_t st;
        ioxp_kind_t kind;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic rw;
        logic acked;
        logic [1:0] ptr;
        logic [7:0] out_reg;
        logic [7:0] pol;
        logic [7:0] drv_en;
        logic sda_oe;
        logic sda_lvl;
    } ioxp_regs_t;

    localparam ioxp_regs_t IOXP_RESET = '{
        scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1,
        sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1,
        pin_s1: 8'h00, pin_s2: 8'h00, adr_s1: 2'h0, adr_s2: 2'h0,
        st: IOXP_IDLE, kind: IOXP_K_ADDR, cnt: 4'h0, shreg: 8'h00,
        rw: 1'b0, acked: 1'b0, ptr: PTR_RST, out_reg: OUT_RST,
        pol: POL_RST, drv_en: ~CFG_RST, sda_oe: 1'b0, sda_lvl: 1'b0
    };
endpackage

//--- src/ioxp_target.sv
// i2c target with command pointer and four port registers of an 8-bit expander
`timescale 1ns/1ns
module ioxp_target
    import ioxp_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [1:0] addr_sel_i,
    input wire logic [7:0] port_i,
    output logic [7:0] port_o,
    output logic [7:0] port_oe_o
);
    logic [1:0] rst_q;
    logic rst_n;
    ioxp_regs_t cur_q;
    ioxp_regs_t nxt_d;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic addr_match;
    logic [7:0] rd_val;

    // reset released synchronously so all state leaves reset on one edge
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_q <= 2'h0;
        else
            rst_q <= {rst_q[0], 1'b1};
    end
    assign rst_n = rst_q[1];

    assign scl_rise = cur_q.scl_s2 & ~cur_q.scl_s3;
    assign scl_fall = ~cur_q.scl_s2 & cur_q.scl_s3;
    assign start_ev = cur_q.scl_s2 & cur_q.scl_s3 & ~cur_q.sda_s2 & cur_q.sda_s3;
    assign stop_ev = cur_q.scl_s2 & cur_q.scl_s3 & cur_q.sda_s2 & ~cur_q.sda_s3;
    assign addr_match = (cur_q.shreg[7:1] == {OWN_ADDR_HI, cur_q.adr_s2});

    always_comb
    begin
        case (cur_q.ptr)
            REG_INPUT: rd_val = cur_q.pin_s2 ^ cur_q.pol;
            REG_OUTPUT: rd_val = cur_q.out_reg;
            REG_POLARITY: rd_val = cur_q.pol;
            default: rd_val = ~cur_q.drv_en;
        endcase
    end

    always_comb
    begin
        nxt_d = cur_q;
        nxt_d.scl_s1 = scl_i;
        nxt_d.scl_s2 = cur_q.scl_s1;
        nxt_d.scl_s3 = cur_q.scl_s2;
        nxt_d.sda_s1 = sda_i;
        nxt_d.sda_s2 = cur_q.sda_s1;
        nxt_d.sda_s3 = cur_q.sda_s2;
        nxt_d.pin_s1 = port_i;
        nxt_d.pin_s2 = cur_q.pin_s1;
        nxt_d.adr_s1 = addr_sel_i;
        nxt_d.adr_s2 = cur_q.adr_s1;
        nxt_d.sda_lvl = 1'b0;
        if (stop_ev)
        begin
            nxt_d.st = IOXP_IDLE;
            nxt_d.sda_oe = 1'b0;
        end
        else if (start_ev)
        begin
            // pointer untouched so a restart reads the selected register
            nxt_d.st = IOXP_RX;
            nxt_d.kind = IOXP_K_ADDR;
            nxt_d.cnt = 4'h0;
            nxt_d.sda_oe = 1'b0;
        end
        else
        begin
            case (cur_q.st)
                IOXP_IDLE:
                begin
                    nxt_d.sda_oe = 1'b0;
                end
                IOXP_RX:
                begin
                    if (scl_rise)
                    begin
                        nxt_d.shreg = {cur_q.shreg[6:0], cur_q.sda_s2};
                        nxt_d.cnt = cur_q.cnt + 4'h1;
                    end
                    else if (scl_fall && cur_q.cnt == BYTE_BITS)
                    begin
                        nxt_d.st = IOXP_RACK;
                        nxt_d.sda_oe = 1'b1;
                        if (cur_q.kind == IOXP_K_ADDR)
                        begin
                            nxt_d.rw = cur_q.shreg[0];
                            if (!addr_match)
                            begin
                                nxt_d.st = IOXP_IDLE;
                                nxt_d.sda_oe = 1'b0;
                            end
                        end
                        else if (cur_q.kind == IOXP_K_CMD)
                            nxt_d.ptr = cur_q.shreg[1:0];
                    end
                end
                IOXP_RACK:
                begin
                    if (scl_rise && cur_q.kind == IOXP_K_DATA)
                    begin
                        // same register every byte, input port writes dropped
                        case (cur_q.ptr)
                            REG_OUTPUT: nxt_d.out_reg = cur_q.shreg;
                            REG_POLARITY: nxt_d.pol = cur_q.shreg;
                            REG_CONFIG: nxt_d.drv_en = ~cur_q.shreg;
                            default: nxt_d.out_reg = cur_q.out_reg;
                        endcase
                    end
                    else if (scl_fall)
                    begin
                        nxt_d.cnt = 4'h0;
                        if (cur_q.kind == IOXP_K_ADDR && cur_q.rw)
                        begin
                            nxt_d.st = IOXP_TX;
                            nxt_d.shreg = rd_val;
                            nxt_d.sda_oe = ~rd_val[7];
                        end
                        else
                        begin
                            nxt_d.st = IOXP_RX;
                            nxt_d.sda_oe = 1'b0;
                            nxt_d.kind = (cur_q.kind == IOXP_K_ADDR) ? IOXP_K_CMD : IOXP_K_DATA;
                        end
                    end
                end
                IOXP_TX:
                begin
                    if (scl_fall)
                    begin
                        if (cur_q.cnt == LAST_TX_BIT)
                        begin
                            nxt_d.st = IOXP_TACK;
                            nxt_d.sda_oe = 1'b0;
                        end
                        else
                        begin
                            nxt_d.cnt = cur_q.cnt + 4'h1;
                            nxt_d.shreg = {cur_q.shreg[6:0], 1'b0};
                            nxt_d.sda_oe = ~cur_q.shreg[6];
                        end
                    end
                end
                IOXP_TACK:
                begin
                    if (scl_rise)
                    begin
                        nxt_d.acked = ~cur_q.sda_s2;
                        if (cur_q.sda_s2)
                            nxt_d.st = IOXP_IDLE;
                    end
                    else if (scl_fall && cur_q.acked)
                    begin
                        // pointer never advances, so the next byte repeats it
                        nxt_d.st = IOXP_TX;
                        nxt_d.cnt = 4'h0;
                        nxt_d.shreg = rd_val;
                        nxt_d.sda_oe = ~rd_val[7];
                    end
                end
                default:
                begin
                    nxt_d.st = IOXP_IDLE;
                    nxt_d.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            cur_q <= IOXP_RESET;
        else
            cur_q <= nxt_d;
    end

    assign sda_o = cur_q.sda_lvl;
    assign sda_oe_o = cur_q.sda_oe;
    assign port_o = cur_q.out_reg;
    assign port_oe_o = cur_q.drv_en;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n);

    stop_release_a: assert property (stop_ev |=> !sda_oe_o && cur_q.st == IOXP_IDLE)
        else $error("stop did not release the data line");
    foreign_addr_a: assert property ((cur_q.st == IOXP_RX && cur_q.kind == IOXP_K_ADDR && scl_fall
        && cur_q.cnt == BYTE_BITS && !addr_match && !start_ev && !stop_ev) |=> cur_q.st == IOXP_IDLE && !sda_oe_o)
        else $error("foreign address was answered");
    cmd_store_a: assert property ((cur_q.st == IOXP_RX && cur_q.kind == IOXP_K_CMD && scl_fall
        && cur_q.cnt == BYTE_BITS && !start_ev && !stop_ev) |=> cur_q.ptr == $past(cur_q.shreg[1:0]) && sda_oe_o)
        else $error("command byte not stored");
    out_capture_a: assert property ((cur_q.st == IOXP_RACK && cur_q.kind == IOXP_K_DATA && scl_rise
        && cur_q.ptr == REG_OUTPUT && !start_ev && !stop_ev) |=> port_o == $past(cur_q.shreg))
        else $error("output data not captured at ack rise");
    restart_keep_a: assert property (start_ev |=> cur_q.ptr == $past(cur_q.ptr))
        else $error("restart moved the register pointer");
    input_ro_a: assert property ((cur_q.st == IOXP_RACK && cur_q.ptr == REG_INPUT)
        |=> port_o == $past(port_o) && port_oe_o == $past(port_oe_o))
        else $error("input port write changed state");
    read_first_a: assert property ((cur_q.st == IOXP_RACK && cur_q.kind == IOXP_K_ADDR && cur_q.rw
        && scl_fall && !start_ev && !stop_ev) |=> cur_q.st == IOXP_TX && sda_oe_o == !$past(rd_val[7]))
        else $error("read data not driven after address ack");
    dir_cfg_a: assert property ((cur_q.st == IOXP_RACK && cur_q.kind == IOXP_K_DATA && scl_rise
        && cur_q.ptr == REG_CONFIG && !start_ev && !stop_ev) |=> port_oe_o == ~$past(cur_q.shreg))
        else $error("direction bits not applied");

    write_cov: cover property (cur_q.st == IOXP_RACK && cur_q.kind == IOXP_K_DATA && scl_rise);
    read_cov: cover property (cur_q.st == IOXP_TACK && scl_rise && !cur_q.sda_s2);
    nack_cov: cover property (cur_q.st == IOXP_TACK && scl_rise && cur_q.sda_s2);
endmodule

//--- verification/ioxp_i2c_master.sv
// i2c master model that drives the expander's serial pins
`timescale 1ns/1ns
module ioxp_i2c_master (
    input wire logic clock_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    // low 5, high 3 clocks; data moves 2 clocks after the fall, sampled late in the high phase
    task automatic bit_x(input logic b, output logic s);
        tick(2);
        sda_o <= b;
        tick(3);
        scl_o <= 1'b1;
        tick(2);
        s = sda_i;
        tick(1);
        scl_o <= 1'b0;
    endtask
    task automatic start();
        tick(1);
        sda_o <= 1'b0;
        tick(4);
        scl_o <= 1'b0;
    endtask
    // extra low time so the target's ack release lands before the clock rises
    task automatic restart();
        tick(3);
        sda_o <= 1'b1;
        tick(3);
        scl_o <= 1'b1;
        tick(4);
        sda_o <= 1'b0;
        tick(4);
        scl_o <= 1'b0;
    endtask
    task automatic stop();
        tick(2);
        sda_o <= 1'b0;
        tick(3);
        scl_o <= 1'b1;
        tick(4);
        sda_o <= 1'b1;
        tick(4);
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], s);
        bit_x(1'b1, s);
        ack = ~s;
    endtask
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_x(1'b1, d[i]);
        bit_x(last, s);
    endtask
endmodule

//--- verification/i2c_expander_register_access_tb.sv
// self-checking bench for the i2c expander register access block
`timescale 1ns/1ns
module i2c_expander_register_access_tb;
    import ioxp_pkg::*;
    localparam logic [7:0] AW = 8'he4;
    localparam logic [7:0] AR = 8'he5;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] ext = 8'h3c;
    logic [1:0] strap = 2'h2;
    logic scl, sda_m, sda_o, sda_oe, ack;
    logic [7:0] port_o, port_oe, rd, rd2;
    int err_count = 0;
    int n_tests = 0;
    wire sda = sda_m & ~(sda_oe & ~sda_o);
    wire [7:0] pins = (port_oe & port_o) | (~port_oe & ext);
    always #10 clock_i = ~clock_i;
    ioxp_i2c_master u_mst (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
    ioxp_target u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .addr_sel_i(strap), .port_i(pins), .port_o(port_o), .port_oe_o(port_oe));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic put(input logic [7:0] cmd, input logic [7:0] d);
        u_mst.start();
        u_mst.wr_byte(AW, ack);
        chk("addr ack", 8'h1, {7'h0, ack});
        u_mst.wr_byte(cmd, ack);
        u_mst.wr_byte(d, ack);
        chk("data ack", 8'h1, {7'h0, ack});
        u_mst.stop();
    endtask
    task automatic get(output logic [7:0] d);
        u_mst.start();
        u_mst.wr_byte(AR, ack);
        u_mst.rd_byte(1'b1, d);
        u_mst.stop();
    endtask
    task automatic sel_rd(input logic [7:0] cmd, output logic [7:0] a, output logic [7:0] b);
        u_mst.start();
        u_mst.wr_byte(AW, ack);
        u_mst.wr_byte(cmd, ack);
        u_mst.restart();
        u_mst.wr_byte(AR, ack);
        u_mst.rd_byte(1'b0, a);
        u_mst.rd_byte(1'b1, b);
        u_mst.stop();
    endtask
    task automatic t_reset();
        chk("out reset", OUT_RST, port_o);
        chk("oe reset", ~CFG_RST, port_oe);
        chk("sda idle", 8'h0, {7'h0, sda_oe});
        chk("sda drive", 8'h0, {7'h0, sda_o});
        get(rd);
        chk("direct input", ext, rd);
    endtask
    task automatic t_multi();
        u_mst.start();
        u_mst.wr_byte(AW, ack);
        u_mst.wr_byte(8'h41, ack);
        u_mst.wr_byte(8'h11, ack);
        u_mst.wr_byte(8'h22, ack);
        u_mst.wr_byte(8'h5a, ack);
        u_mst.stop();
        chk("out multi", 8'h5a, port_o);
        get(rd);
        chk("out readback", 8'h5a, rd);
    endtask
    task automatic t_cfg_pol();
        put(8'h03, 8'h0f);
        chk("oe cfg", 8'hf0, port_oe);
        sel_rd(8'h03, rd, rd2);
        chk("cfg read", 8'h0f, rd);
        chk("cfg again", 8'h0f, rd2);
        put(8'h02, 8'h81);
        sel_rd(8'h00, rd, rd2);
        chk("input pol", 8'hdd, rd);
        chk("input again", 8'hdd, rd2);
        put(8'h00, 8'h00);
        chk("out kept", 8'h5a, port_o);
        chk("oe kept", 8'hf0, port_oe);
        sel_rd(8'h02, rd, rd2);
        chk("pol first", 8'h81, rd);
        chk("pol second", 8'h81, rd2);
        get(rd);
        chk("pol repeat", 8'h81, rd);
    endtask
    task automatic t_foreign();
        u_mst.start();
        u_mst.wr_byte(8'he0, ack);
        chk("foreign ack", 8'h0, {7'h0, ack});
        u_mst.wr_byte(8'h01, ack);
        u_mst.wr_byte(8'h00, ack);
        u_mst.stop();
        chk("out foreign", 8'h5a, port_o);
        // straps change only between transactions
        strap <= 2'h0;
        u_mst.tick(4);
        u_mst.start();
        u_mst.wr_byte(8'he0, ack);
        chk("strap ack", 8'h1, {7'h0, ack});
        u_mst.stop();
        strap <= 2'h2;
        u_mst.tick(4);
    endtask
    task automatic t_stop_mid();
        u_mst.start();
        u_mst.wr_byte(AW, ack);
        u_mst.wr_byte(8'h01, ack);
        repeat (4) u_mst.bit_x(1'b0, ack);
        u_mst.stop();
        chk("out partial", 8'h5a, port_o);
        chk("sda released", 8'h1, {7'h0, sda});
        put(8'h01, 8'ha5);
        chk("out after stop", 8'ha5, port_o);
    endtask
    initial
    begin
        repeat (8) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (6) @(posedge clock_i);
        t_reset();
        t_multi();
        t_cfg_pol();
        t_foreign();
        t_stop_mid();
        complete_run();
    end
    // bounds the whole run so a stuck bus cannot hang the bench
    initial
    begin
        repeat (20000) @(posedge clock_i);
        err_count++;
        $display("BAD watchdog exp done got timeout");
        complete_run();
    end
endmodule
